// >>> core/dmr_pkg.sv
/*
 * dmr_pkg: constants and carrier types for the mode register block of a
 * DDR4-style device.
 * Assumes a single 100 MHz system clock and an AHB-Lite register bus.
 */
package dmr_pkg;

    // timing
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int INIT_WAIT_US    = 500;
    localparam int INIT_WAIT_CYC   = (INIT_WAIT_US * 1000000) / CLK_PERIOD_PS;
    localparam int CKE_SETUP_NS    = 10;
    localparam int CKE_SETUP_CYC   = (CKE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // mode register set
    localparam int          MR_COUNT     = 7;
    localparam int          MR_WIDTH     = 18;
    localparam logic [2:0]  MR_SEL_CTRLW = 3'h7;
    localparam logic [17:0] MR_RESET_VAL = 18'h00000;

    // register map, byte addresses
    localparam logic [7:0] ADDR_MR_BASE = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h20;
    localparam logic [7:0] ADDR_CTRL    = 8'h24;
    localparam logic [7:0] ADDR_MRCOUNT = 8'h28;

    // status bits
    localparam int ST_READY_BIT    = 0;
    localparam int ST_CKE_BIT      = 1;
    localparam int ST_RTT_ON_BIT   = 2;
    localparam int ST_ODT_IGN_BIT  = 3;
    localparam int ST_IGNORED_BIT  = 4;
    // control bits
    localparam int CTRL_CLR_BIT    = 0;

    typedef enum logic [3:0] {
        DMR_RESET = 4'b0001,
        DMR_INIT  = 4'b0010,
        DMR_WCKE  = 4'b0100,
        DMR_READY = 4'b1000
    } dmr_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       act_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic       bg1;
        logic [2:0] sel;
        logic [17:0] addr;
    } dmr_cmd_t;

endpackage

// >>> core/dmr_mrs_decode.sv
/*
 * dmr_mrs_decode: recognises a mode register set command on the command
 * bus and gives the target register index.
 * Assumes command inputs already sampled on the system clock.
 */
`timescale 1ns/100ps
module dmr_mrs_decode
(
    // command in
    input  wire dmr_pkg::dmr_cmd_t cmd,
    input  wire logic              cke,
    // decode out
    output logic                   mrs_hit,
    output logic                   mrs_ctrlword,
    output logic [2:0]             mrs_sel
);
    import dmr_pkg::*;

    logic is_mrs;

    assign is_mrs       = cke && !cmd.cs_n && cmd.act_n && !cmd.ras_n && !cmd.cas_n
                          && !cmd.we_n;
    assign mrs_sel      = cmd.sel;
    assign mrs_ctrlword = is_mrs && (cmd.sel == MR_SEL_CTRLW);
    assign mrs_hit      = is_mrs && (cmd.sel != MR_SEL_CTRLW);
endmodule

// >>> core/dmr_top.sv
/*
 * dmr_top: device-side reset sequencing and mode register storage of a
 * DDR4-style memory, with the mode registers also visible over AHB-Lite.
 * Assumes sys_clk is the command clock and all pins are synchronous to it.
 */
`timescale 1ns/100ps
module dmr_top
#(
    parameter int INIT_CYCLES = dmr_pkg::INIT_WAIT_CYC
)
(
    // system
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // memory pins
    input  wire logic              mem_reset_n,
    input  wire logic              mem_cke,
    input  wire logic              mem_odt,
    input  wire dmr_pkg::dmr_cmd_t mem_cmd,
    // device status
    output logic                   init_done,
    output logic                   rtt_nom_on,
    output logic                   odt_ignored,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp
);
    import dmr_pkg::*;

    logic                mrs_hit;
    logic                mrs_ctrlword;
    logic [2:0]          mrs_sel;

    dmr_mrs_decode u_dec
    (
        .cmd          (mem_cmd),
        .cke          (mem_cke),
        .mrs_hit      (mrs_hit),
        .mrs_ctrlword (mrs_ctrlword),
        .mrs_sel      (mrs_sel)
    );

    // sequencing state
    dmr_state_t          st_q, st_d;
    logic [31:0]         cnt_q, cnt_d;

    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            DMR_RESET:
            begin
                cnt_d = '0;
                if (mem_reset_n)
                    st_d = DMR_INIT;
            end
            DMR_INIT:
            begin
                // internal init runs without needing CKE or the clock's commands
                if (cnt_q >= 32'(INIT_CYCLES - 1))
                    st_d = DMR_WCKE;
                else
                    cnt_d = cnt_q + 32'h1;
            end
            DMR_WCKE:
                if (mem_cke)
                    st_d = DMR_READY;
            DMR_READY:
                st_d = DMR_READY;
            default:
                st_d = DMR_RESET;
        endcase
        if (!mem_reset_n)
            st_d = DMR_RESET;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q  <= DMR_RESET;
            cnt_q <= '0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // mode register storage
    logic [MR_WIDTH-1:0] mr_q [MR_COUNT];
    logic [MR_WIDTH-1:0] mr_d [MR_COUNT];
    logic [15:0]         nmrs_q, nmrs_d;
    logic                ign_q, ign_d;
    logic                take_mrs;
    logic                clr_req;

    // mrs accepted only once the device can register commands
    assign take_mrs = mrs_hit && (st_q == DMR_READY) && mem_reset_n;

    always_comb
    begin
        for (int i = 0; i < MR_COUNT; i++)
        begin
            mr_d[i] = mr_q[i];
            if (take_mrs && (mrs_sel == 3'(i)))
                mr_d[i] = mem_cmd.addr;
        end
        nmrs_d = nmrs_q + (take_mrs ? 16'h1 : 16'h0);
        // set wins over clear
        ign_d = (ign_q && !clr_req) || (mrs_ctrlword && st_q == DMR_READY);
        if (!mem_reset_n)
        begin
            // no per-register defaults; pin reset clears every mode register to MR_RESET_VAL
            for (int i = 0; i < MR_COUNT; i++)
                mr_d[i] = MR_RESET_VAL;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < MR_COUNT; i++)
                mr_q[i] <= MR_RESET_VAL;
            nmrs_q <= '0;
            ign_q  <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < MR_COUNT; i++)
                mr_q[i] <= mr_d[i];
            nmrs_q <= nmrs_d;
            ign_q  <= ign_d;
        end
    end

    // termination status: rtt_nom lives in mr1 a[10:8]
    logic rtt_q, rtt_d, odtign_q, odtign_d, done_q, done_d;

    always_comb
    begin
        rtt_d    = (mr_d[1][10:8] != 3'h0);
        // odt is a don't care only if termination stays off across the write
        odtign_d = !rtt_q && !rtt_d;
        done_d   = (st_d == DMR_READY);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rtt_q    <= 1'b0;
            odtign_q <= 1'b1;
            done_q   <= 1'b0;
        end
        else
        begin
            rtt_q    <= rtt_d;
            odtign_q <= odtign_d;
            done_q   <= done_d;
        end
    end

    assign init_done   = done_q;
    assign rtt_nom_on  = rtt_q;
    assign odt_ignored = odtign_q;

    // ahb-lite slave, zero wait states
    logic        aph_q, aph_d, awr_q, awr_d;
    logic [7:0]  aad_q, aad_d;
    logic [31:0] rd_q, rd_d;

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        if (a < ADDR_STATUS && a[1:0] == 2'h0 && a[7:2] < 6'(MR_COUNT))
            v = {14'h0, mr_q[a[4:2]]};
        else if (a == ADDR_STATUS)
            v = {27'h0, ign_q, odtign_q, rtt_q, mem_cke, done_q};
        else if (a == ADDR_MRCOUNT)
            v = {16'h0, nmrs_q};
        return v;
    endfunction

    always_comb
    begin
        aph_d = hsel && hready && htrans[1];
        awr_d = hwrite;
        aad_d = haddr;
        rd_d  = rd_mux(haddr);
    end

    // mode registers are read-only to software; only ctrl clears the flag
    assign clr_req = aph_q && awr_q && aad_q == ADDR_CTRL && hwdata[CTRL_CLR_BIT];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            aph_q <= 1'b0;
            awr_q <= 1'b0;
            aad_q <= '0;
            rd_q  <= '0;
        end
        else
        begin
            aph_q <= aph_d;
            awr_q <= awr_d;
            aad_q <= aad_d;
            rd_q  <= rd_d;
        end
    end

    // zero wait and always okay, still registered so every output is a flop
    logic rdy_q, resp_q;

    always_ff @(posedge sys_clk)
    begin
        rdy_q  <= 1'b1;
        resp_q <= 1'b0;
    end

    assign hrdata    = rd_q;
    assign hreadyout = rdy_q;
    assign hresp     = resp_q;
endmodule

// >>> bench/dmr_top_sva.sv
/* pin and status checks for dmr_top
   assumes the bind below */
`timescale 1ns/100ps
module dmr_top_sva
#(
    parameter int INIT_CYCLES = 20
)
(
    // system
    input wire logic              sys_clk,
    input wire logic              rst,
    // memory pins
    input wire logic              mem_reset_n,
    input wire logic              mem_cke,
    input wire dmr_pkg::dmr_cmd_t mem_cmd,
    // status and bus
    input wire logic              init_done,
    input wire logic              rtt_nom_on,
    input wire logic              odt_ignored,
    input wire logic              hreadyout,
    input wire logic              hresp
);
    import dmr_pkg::*;
    int unsigned up_d;
    int unsigned up_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence mrs_s(logic [2:0] s);
        mem_cke && !mem_cmd.cs_n && mem_cmd.act_n && !mem_cmd.ras_n && !mem_cmd.cas_n
            && !mem_cmd.we_n && mem_cmd.sel == s;
    endsequence
    always_comb up_d = mem_reset_n ? up_q + 1 : 0;
    always_ff @(posedge sys_clk) up_q <= up_d;
    bus_ready_a: assert property (hreadyout) else $error("slave stalled");
    bus_okay_a: assert property (!hresp) else $error("error response");
    init_len_a: assert property (init_done |-> up_q >= INIT_CYCLES)
        else $error("ready before init wait");
    pin_reset_a: assert property (!mem_reset_n |=> !init_done)
        else $error("ready during pin reset");
    rtt_on_a: assert property (init_done ##0 mrs_s(3'h1) ##0 mem_cmd.addr[10:8] != 3'h0
        |-> ##[2:3] rtt_nom_on) else $error("termination not on");
    rtt_off_a: assert property (init_done ##0 mrs_s(3'h1) ##0 mem_cmd.addr[10:8] == 3'h0
        |-> ##[2:3] !rtt_nom_on) else $error("termination not off");
    ctrlword_a: assert property (mrs_s(3'h7) |=> $stable(rtt_nom_on) [*3])
        else $error("control word changed state");
    odt_busy_a: assert property (odt_ignored == (!rtt_nom_on && !$past(rtt_nom_on)))
        else $error("odt ignored state wrong");
endmodule
bind dmr_top dmr_top_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (.sys_clk, .rst, .mem_reset_n,
    .mem_cke, .mem_cmd, .init_done, .rtt_nom_on, .odt_ignored, .hreadyout, .hresp);

// >>> bench/dmr_ctl_model.sv
/* memory controller model: reset, cke, odt, commands
   assumes tasks are entered just after a clock edge */
`timescale 1ns/100ps
module dmr_ctl_model
#(
    parameter int INIT_CYCLES = 20
)
(
    // clock
    input wire logic          sys_clk,
    // memory pins
    output logic              mem_reset_n,
    output logic              mem_cke,
    output logic              mem_odt,
    output dmr_pkg::dmr_cmd_t mem_cmd
);
    import dmr_pkg::*;
    // waits in whole clocks, plain defaults
    localparam int TMOD = 24; // also covers tMRD
    localparam int ODT_LEAD = 6;
    initial
    begin
        mem_reset_n = 1'b0;
        mem_cke = 1'b0;
        mem_odt = 1'b0;
        mem_cmd = '1;
    end
    // deselect; idle address lines wander so stale values never match
    task automatic idle(input int n);
        repeat (n)
        begin
            mem_cmd <= dmr_cmd_t'(~mem_cmd | 27'h4000000);
            @(posedge sys_clk);
        end
    endtask
    task automatic power_up(input int low);
        mem_cke <= 1'b0;
        mem_reset_n <= 1'b0;
        idle(low);
        mem_reset_n <= 1'b1;
        idle(INIT_CYCLES);
        mem_cke <= 1'b1;
        idle(5);
    endtask
    task automatic mrs(input logic [2:0] sel, input logic [17:0] val);
        mem_odt <= 1'b0;
        idle(ODT_LEAD);
        mem_cmd <= dmr_cmd_t'({6'b010000, sel, val});
        @(posedge sys_clk);
        idle(TMOD);
        mem_odt <= 1'b1;
        idle(1);
    endtask
endmodule

// >>> bench/tb_dmr_top.sv
/* self-checking bench for dmr_top
   assumes dmr_ctl_model drives the memory pins */
`timescale 1ns/100ps
module tb_dmr_top;
    import dmr_pkg::*;
    localparam logic [2:0] ORD[7] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, mem_reset_n, mem_cke, mem_odt, init_done, rtt_nom_on, odt_ignored;
    dmr_cmd_t mem_cmd;
    logic [17:0] mr[7];
    logic [17:0] v;
    logic [2:0] s;
    logic ign;
    int fails = 0;
    int num_checks = 0;
    int cnt;
    always #5 sys_clk = ~sys_clk;
    dmr_ctl_model #(.INIT_CYCLES(20)) u_ctl (.sys_clk, .mem_reset_n, .mem_cke, .mem_odt,
        .mem_cmd);
    dmr_top #(.INIT_CYCLES(20)) DUT (.sys_clk, .rst, .mem_reset_n, .mem_cke, .mem_odt,
        .mem_cmd, .init_done, .rtt_nom_on, .odt_ignored, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    // status once ready: flag, odt ignored, termination, cke, done
    function automatic logic [31:0] exp_st(input logic i);
        logic r;
        r = mr[1][10:8] != 3'h0;
        return {27'h0, i, ~r, r, 2'b11};
    endfunction
    task automatic check_all(input int n);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, ADDR_MR_BASE + 8'(4 * i), 32'h0);
            chk(rd, {14'h0, mr[i]});
        end
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, exp_st(ign));
        if (n >= 0)
        begin
            bus(1'b0, ADDR_MRCOUNT, 32'h0);
            chk(rd, 32'(n));
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h6286));
        foreach (mr[i]) mr[i] = 18'h0;
        ign = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b1, ADDR_MR_BASE + 8'h08, 32'h3FFFF);
        bus(1'b0, ADDR_MR_BASE + 8'h08, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h8);
        // command before init with cke low must not land
        u_ctl.mrs(3'h2, 18'h155AA);
        bus(1'b0, ADDR_MR_BASE + 8'h08, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, ADDR_MRCOUNT, 32'h0);
        chk(rd, 32'h0);
        $display("test idle done");
        u_ctl.power_up(4);
        foreach (ORD[k])
        begin
            v = 18'($urandom);
            mr[ORD[k]] = v;
            u_ctl.mrs(ORD[k], v);
        end
        cnt = 7;
        check_all(cnt);
        $display("test init done");
        for (int k = 0; k < 12; k++)
        begin
            s = (k == 0) ? 3'h7 : (k[0] ? 3'h1 : 3'($urandom));
            v = 18'($urandom);
            if (k == 1) v[10:8] = 3'h0;
            u_ctl.mrs(s, v);
            if (s == 3'h7) ign = 1'b1;
            else
            begin
                mr[s] = v;
                cnt++;
            end
            check_all(cnt);
        end
        $display("test rewrite done");
        bus(1'b1, ADDR_CTRL, 32'h1);
        ign = 1'b0;
        check_all(cnt);
        $display("test clear done");
        u_ctl.power_up(3);
        foreach (mr[i]) mr[i] = 18'h0;
        check_all(-1);
        $display("test pin reset done");
        close_out();
    end
endmodule
